// >>> design/coc_regs.svh
// register offsets, field positions and constants of the overlay checker
`ifndef COC_REGS_SVH
`define COC_REGS_SVH
`define COC_ADR_CTRL     4'h0
`define COC_ADR_DATA     4'h1
`define COC_ADR_STAT     4'h2
`define COC_ADR_RESULT   4'h3
`define COC_ADR_W63      4'h4
`define COC_ADR_W88      4'h5
`define COC_ADR_W82      4'h6
`define COC_ADR_W83      4'h7
`define COC_ADR_W84      4'h8
`define COC_ADR_W94      4'h9
`define COC_ADR_MAXLBA0  4'ha
`define COC_ADR_MAXLBA1  4'hb
`define COC_ADR_STATE    4'hc
`define COC_ADR_NATIVE0  4'hd
`define COC_ADR_NATIVE1  4'he
`define COC_REVISION     16'h0001
`define COC_SIGNATURE    8'ha5
`define COC_LAST_WORD    8'hff
`define COC_CH_CSUM      8'hff
`define COC_CH_REV       8'h00
`define COC_CH_MAXLBA    8'h03
`define COC_W63_RST      16'h0007
`define COC_W88_RST      16'h003f
`define COC_W82_RST      16'h0403
`define COC_W83_RST      16'h0762
`define COC_W84_RST      16'h0003
`define COC_W94_RST      16'h8080
`define COC_NATIVE_RST   48'h0400_0000_0000
`define COC_CTRL_START   0
`define COC_STAT_BSY     7
`define COC_STAT_DRDY    6
`define COC_STAT_ERR     0
`define COC_ERR_ABRT     2
`endif

// >>> design/coc_pkg.sv
// types of the overlay checker
package coc_pkg;
    typedef enum logic [1:0] {IDLE, LOAD, CHECK, APPLY} coc_state_type;
endpackage

// >>> design/coc_top.sv
// device configuration overlay checker with wishbone register access
// Operation
// - first overlay word must be revision 0001h, else abort
// - clearing mwdma2 clears w63 bit2; refused while mwdma2 active
// - clearing mwdma1 clears w63 bit1; refused if mode2 kept or 1/2 active
// - clearing mwdma0 is always rejected
// - clearing udma5 clears w88 bit5; refused while udma5 selected
// - clearing udma n refused if higher kept or n-or-higher selected
// - words 3-6 set max lba; identify words 60,61,100-103 follow
// - with protected area established, max lba kept and command aborted
// - data in protected region untouched by max lba change
// - clearing w7 bit8 clears bit10 of 83/86 and keeps only the low 28 bits of max lba
// - clearing w7 bit7 clears 82/85 b10, 83/86 b8; refused with hpa
// - clearing w7 bit6 clears w83 bit9 and acoustic word 94
// - clearing w7 bit5 clears bit1 of words 83 and 86
// - clearing w7 bit4 clears bits 5,6 and word 94; refused by jumper
// - clearing w7 bit3 clears bit1 of 82/85; refused if security on
// - w7 bit2 clears 84/87 bit0; bit1 clears 84/87 bit1
// - clearing w7 bit0 clears 82/85 bit0; aborts if bits1,2 kept or on
// - last word low byte a5h, high byte two's complement checksum
// - all bytes of words 0-255 summed modulo 256 must be zero
// - checksum failure aborts with ffh in cylinder high
// - illegal max lba aborts with offset 3 in cylinder high
// - overlay bits set where current config is clear are ignored
`timescale 1ns/1ps
`default_nettype none
`include "coc_regs.svh"
module coc_top
(
    // clock and reset
    input  wire logic        CLK,
    input  wire logic        SRST,
    // wishbone slave
    input  wire logic        WB_CYC_I,
    input  wire logic        WB_STB_I,
    input  wire logic        WB_WE_I,
    input  wire logic [5:0]  WB_ADR_I,
    input  wire logic [3:0]  WB_SEL_I,
    input  wire logic [31:0] WB_DAT_I,
    output logic [31:0]      WB_DAT_O,
    output logic             WB_ACK_O,
    // drive state pins
    input  wire logic [2:0]  MWDMA_SEL,
    input  wire logic        MWDMA_SEL_VALID,
    input  wire logic [2:0]  UDMA_SEL,
    input  wire logic        UDMA_SEL_VALID,
    input  wire logic        HPA_SET,
    input  wire logic        PUIS_JUMPER,
    input  wire logic        SECURITY_ON,
    input  wire logic        SMART_ON,
    // completion
    output logic             CMD_DONE
);
    // two-flop sync of drive state pins
    logic [11:0] pin_s1_r;
    logic [11:0] pin_s2_r;
    logic [2:0]  mw_sel;
    logic        mw_val;
    logic [2:0]  ud_sel;
    logic        ud_val;
    logic        hpa;
    logic        puis;
    logic        sec;
    logic        smart;

    always_ff @(posedge CLK)
    begin
        pin_s1_r <= {MWDMA_SEL, MWDMA_SEL_VALID, UDMA_SEL, UDMA_SEL_VALID,
                     HPA_SET, PUIS_JUMPER, SECURITY_ON, SMART_ON};
        pin_s2_r <= pin_s1_r;
    end
    assign {mw_sel, mw_val, ud_sel, ud_val, hpa, puis, sec, smart} = pin_s2_r;

    // state
    coc_pkg::coc_state_type st_r, st_nxt;
    logic [7:0]  idx_r, idx_nxt;
    logic [7:0]  sum_r, sum_nxt;
    logic [15:0] ov_r [0:7];
    logic [15:0] ov_nxt [0:7];
    logic [15:0] w63_r, w63_nxt, w88_r, w88_nxt;
    logic [15:0] w82_r, w82_nxt, w83_r, w83_nxt;
    logic [15:0] w84_r, w84_nxt, w94_r, w94_nxt;
    logic [47:0] maxlba_r, maxlba_nxt;
    logic [7:0]  err_r, err_nxt, sn_r, sn_nxt, cl_r, cl_nxt, ch_r, ch_nxt;
    logic [7:0]  stat_r, stat_nxt;
    logic        done_r, done_nxt;
    logic        ack_r, ack_nxt;
    logic [31:0] dat_r, dat_nxt;
    logic [47:0] native_r;

    // bus decode
    logic        wb_req;
    logic        wr_ctrl;
    logic        wr_data;
    logic [3:0]  adr;
    assign wb_req  = WB_CYC_I && WB_STB_I && !ack_r;
    assign adr     = WB_ADR_I[5:2];
    assign wr_ctrl = wb_req && WB_WE_I && adr == `COC_ADR_CTRL
                     && WB_SEL_I[0] && WB_DAT_I[`COC_CTRL_START];
    assign wr_data = wb_req && WB_WE_I && adr == `COC_ADR_DATA
                     && (&WB_SEL_I[1:0]);

    // restriction evaluation on the latched overlay
    logic [15:0] clr1, clr2, clr7, bad1, bad2, bad7;
    logic [15:0] new_w63, new_w88, new_w82, new_w83, new_w84, new_w94;
    logic [47:0] req_lba;
    logic        lba_change, lba_bad, rev_bad;

    always_comb
    begin
        // ignore bits the current config already reports clear
        clr1 = w63_r & ~ov_r[1] & 16'h0007;
        clr2 = w88_r & ~ov_r[2] & 16'h003f;
        clr7 = {7'h00, w83_r[10], w82_r[10], w83_r[9], w83_r[1],
                w83_r[5], w82_r[1], w84_r[0], w84_r[1], w82_r[0]}
               & ~ov_r[7] & 16'h01ff;
        bad1 = 16'h0000;
        bad1[2] = clr1[2] && mw_val && mw_sel == 3'd2;
        bad1[1] = clr1[1] && (!clr1[2] && w63_r[2]
                  || mw_val && (mw_sel == 3'd1 || mw_sel == 3'd2));
        bad1[0] = clr1[0];
        bad2 = 16'h0000;
        bad2[5] = clr2[5] && ud_val && ud_sel == 3'd5;
        for (int n = 0; n < 5; n++)
        begin
            bad2[n] = clr2[n] && ((|((w88_r & ~clr2 & 16'h003f) >> (n + 1)))
                      || ud_val && 32'(ud_sel) >= n);
        end
        bad7 = 16'h0000;
        bad7[7] = clr7[7] && hpa;
        bad7[4] = clr7[4] && puis;
        bad7[3] = clr7[3] && sec;
        bad7[0] = clr7[0] && (!clr7[1] || !clr7[2] || smart);
        req_lba    = {ov_r[6], ov_r[5], ov_r[4]};
        lba_change = {ov_r[6], ov_r[5], ov_r[4], ov_r[3]} != {maxlba_r,
                     16'h0000};
        lba_bad    = lba_change && (hpa || ov_r[3] != 16'h0000
                     || {ov_r[3], ov_r[4], ov_r[5], ov_r[6]} == 64'h0
                     || {ov_r[6], ov_r[5], ov_r[4]} > native_r);
        rev_bad    = ov_r[0] != `COC_REVISION;
        // new capability words, only committed in apply
        new_w63 = w63_r & ~clr1;
        new_w88 = w88_r & ~clr2;
        new_w82 = w82_r;
        new_w83 = w83_r;
        new_w84 = w84_r;
        new_w94 = w94_r;
        if (clr7[8]) new_w83[10] = 1'b0;
        if (clr7[7])
        begin
            new_w82[10] = 1'b0;
            new_w83[8]  = 1'b0;
        end
        if (clr7[6])
        begin
            new_w83[9] = 1'b0;
            new_w94    = 16'h0000;
        end
        if (clr7[5]) new_w83[1] = 1'b0;
        if (clr7[4])
        begin
            new_w83[6:5] = 2'b00;
            new_w94      = 16'h0000;
        end
        if (clr7[3]) new_w82[1] = 1'b0;
        if (clr7[2]) new_w84[0] = 1'b0;
        if (clr7[1]) new_w84[1] = 1'b0;
        if (clr7[0]) new_w82[0] = 1'b0;
    end
    assign native_r = `COC_NATIVE_RST;

    // next-state logic
    always_comb
    begin
        st_nxt = st_r;
        idx_nxt = idx_r;
        sum_nxt = sum_r;
        for (int i = 0; i < 8; i++) ov_nxt[i] = ov_r[i];
        w63_nxt = w63_r;
        w88_nxt = w88_r;
        w82_nxt = w82_r;
        w83_nxt = w83_r;
        w84_nxt = w84_r;
        w94_nxt = w94_r;
        maxlba_nxt = maxlba_r;
        err_nxt = err_r;
        sn_nxt = sn_r;
        cl_nxt = cl_r;
        ch_nxt = ch_r;
        stat_nxt = stat_r;
        done_nxt = 1'b0;
        unique case (st_r)
            coc_pkg::IDLE:
                if (wr_ctrl)
                begin
                    st_nxt = coc_pkg::LOAD;
                    idx_nxt = 8'h00;
                    sum_nxt = 8'h00;
                    stat_nxt = 8'h80;
                    err_nxt = 8'h00;
                end
            coc_pkg::LOAD:
                if (wr_data)
                begin
                    // modulo-256 byte sum, carries dropped
                    sum_nxt = sum_r + WB_DAT_I[7:0] + WB_DAT_I[15:8];
                    if (idx_r < 8'd8) ov_nxt[idx_r[2:0]] = WB_DAT_I[15:0];
                    if (idx_r == `COC_LAST_WORD)
                    begin
                        // signature folded into check as checksum fault
                        if (WB_DAT_I[7:0] != `COC_SIGNATURE)
                            sum_nxt = 8'h01;
                        st_nxt = coc_pkg::CHECK;
                    end
                    idx_nxt = idx_r + 8'h01;
                end
            coc_pkg::CHECK:
            begin
                // every check decided before any write-back
                st_nxt = coc_pkg::IDLE;
                done_nxt = 1'b1;
                sn_nxt = 8'h00;
                cl_nxt = 8'h00;
                ch_nxt = 8'h00;
                if (sum_r != 8'h00)
                    ch_nxt = `COC_CH_CSUM;
                else if (rev_bad)
                    ch_nxt = `COC_CH_REV;
                else if (|bad1)
                begin
                    ch_nxt = 8'h01;
                    sn_nxt = bad1[7:0];
                end
                else if (|bad2)
                begin
                    ch_nxt = 8'h02;
                    sn_nxt = bad2[7:0];
                end
                else if (lba_bad)
                    ch_nxt = `COC_CH_MAXLBA;
                else if (|bad7)
                begin
                    ch_nxt = 8'h07;
                    sn_nxt = bad7[7:0];
                    cl_nxt = bad7[15:8];
                end
                else
                    st_nxt = coc_pkg::APPLY;
                if (st_nxt == coc_pkg::IDLE)
                begin
                    err_nxt = 8'h04;
                    stat_nxt = 8'h41;
                end
                else
                    done_nxt = 1'b0;
            end
            coc_pkg::APPLY:
            begin
                w63_nxt = new_w63;
                w88_nxt = new_w88;
                w82_nxt = new_w82;
                w83_nxt = new_w83;
                w84_nxt = new_w84;
                w94_nxt = new_w94;
                // only the reported limit moves, media is never touched
                if (lba_change) maxlba_nxt = req_lba;
                if (!new_w83[10]) maxlba_nxt = (lba_change ? req_lba
                    : maxlba_r) & 48'h0000_0fff_ffff;
                stat_nxt = 8'h40;
                done_nxt = 1'b1;
                st_nxt = coc_pkg::IDLE;
            end
        endcase
    end

    // bus answer: ack one cycle after request, unmapped reads zero
    always_comb
    begin
        ack_nxt = wb_req;
        dat_nxt = 32'h0000_0000;
        if (wb_req && !WB_WE_I)
        begin
            unique case (adr)
                `COC_ADR_STAT:    dat_nxt = {24'h0, stat_r};
                `COC_ADR_RESULT:  dat_nxt = {err_r, sn_r, cl_r, ch_r};
                `COC_ADR_W63:     dat_nxt = {16'h0, w63_r};
                `COC_ADR_W88:     dat_nxt = {16'h0, w88_r};
                `COC_ADR_W82:     dat_nxt = {16'h0, w82_r};
                `COC_ADR_W83:     dat_nxt = {16'h0, w83_r};
                `COC_ADR_W84:     dat_nxt = {16'h0, w84_r};
                `COC_ADR_W94:     dat_nxt = {16'h0, w94_r};
                `COC_ADR_MAXLBA0: dat_nxt = maxlba_r[31:0];
                `COC_ADR_MAXLBA1: dat_nxt = {16'h0, maxlba_r[47:32]};
                `COC_ADR_STATE:   dat_nxt = {22'h0, st_r, idx_r};
                default:          dat_nxt = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge CLK)
    begin
        if (SRST)
        begin
            st_r <= coc_pkg::IDLE;
            idx_r <= 8'h00;
            sum_r <= 8'h00;
            for (int i = 0; i < 8; i++) ov_r[i] <= 16'h0000;
            w63_r <= `COC_W63_RST;
            w88_r <= `COC_W88_RST;
            w82_r <= `COC_W82_RST;
            w83_r <= `COC_W83_RST;
            w84_r <= `COC_W84_RST;
            w94_r <= `COC_W94_RST;
            maxlba_r <= `COC_NATIVE_RST;
            err_r <= 8'h00;
            sn_r <= 8'h00;
            cl_r <= 8'h00;
            ch_r <= 8'h00;
            stat_r <= 8'h40;
            done_r <= 1'b0;
            ack_r <= 1'b0;
            dat_r <= 32'h0000_0000;
        end
        else
        begin
            st_r <= st_nxt;
            idx_r <= idx_nxt;
            sum_r <= sum_nxt;
            for (int i = 0; i < 8; i++) ov_r[i] <= ov_nxt[i];
            w63_r <= w63_nxt;
            w88_r <= w88_nxt;
            w82_r <= w82_nxt;
            w83_r <= w83_nxt;
            w84_r <= w84_nxt;
            w94_r <= w94_nxt;
            maxlba_r <= maxlba_nxt;
            err_r <= err_nxt;
            sn_r <= sn_nxt;
            cl_r <= cl_nxt;
            ch_r <= ch_nxt;
            stat_r <= stat_nxt;
            done_r <= done_nxt;
            ack_r <= ack_nxt;
            dat_r <= dat_nxt;
        end
    end

    assign WB_ACK_O = ack_r;
    assign WB_DAT_O = dat_r;
    assign CMD_DONE = done_r;

    // checks
    sequence coc_abort_seq;
        st_r == coc_pkg::CHECK && st_nxt == coc_pkg::IDLE;
    endsequence
    sequence coc_pulse_seq;
        done_r ##1 !done_r;
    endsequence
    AST_ABORT_FLAGS: assert property (@(posedge CLK) disable iff (SRST)
        coc_abort_seq |=> err_r == 8'h04 && stat_r == 8'h41 && done_r)
        else $error("abort without abrt/err/done");
    AST_DONE_PULSE: assert property (@(posedge CLK) disable iff (SRST)
        coc_abort_seq |=> coc_pulse_seq)
        else $error("abort completion is not a single pulse");
    AST_CSUM_CH: assert property (@(posedge CLK) disable iff (SRST)
        st_r == coc_pkg::CHECK && sum_r != 8'h00 |=> ch_r == 8'hff)
        else $error("checksum fault not reported");
    AST_REV: assert property (@(posedge CLK) disable iff (SRST)
        st_r == coc_pkg::CHECK && sum_r == 8'h00 && rev_bad
        |=> ch_r == 8'h00 && err_r[2])
        else $error("bad revision not aborted");
    AST_MW0: assert property (@(posedge CLK) disable iff (SRST)
        st_r == coc_pkg::CHECK && clr1[0] |=> st_r == coc_pkg::IDLE
        && err_r[2])
        else $error("mwdma0 clear accepted");
    AST_NOCHG_ABORT: assert property (@(posedge CLK) disable iff (SRST)
        coc_abort_seq |=>
        $stable(w63_r) && $stable(w88_r) && $stable(maxlba_r))
        else $error("capability changed on abort");
    AST_HPA_LBA: assert property (@(posedge CLK) disable iff (SRST)
        st_r == coc_pkg::CHECK && sum_r == 8'h00 && !rev_bad && ~|bad1
        && ~|bad2 && lba_change && hpa |=> ch_r == 8'h03)
        else $error("lba change with protected area not aborted");
    AST_SMART: assert property (@(posedge CLK) disable iff (SRST)
        st_r == coc_pkg::CHECK && clr7[0] && smart |=>
        st_r == coc_pkg::IDLE && err_r[2])
        else $error("smart clear accepted while enabled");
    AST_APPLY_W63: assert property (@(posedge CLK) disable iff (SRST)
        st_r == coc_pkg::APPLY |=> w63_r == $past(new_w63)
        && w88_r == $past(new_w88) && done_r)
        else $error("capability words not applied");
endmodule // coc_top
`default_nettype wire

// >>> tb/coc_host.sv
// host model: wishbone master that forms and sends overlays
`timescale 1ns/1ps
`default_nettype none
module coc_host
(
    // clock
    input  wire logic        clk,
    // wishbone master side
    output logic             cyc,
    output logic             stb,
    output logic             we,
    output logic [5:0]       adr,
    output logic [3:0]       sel,
    output logic [31:0]      dat,
    input  wire logic        ack
);
    logic [15:0] ov [256];
    logic [7:0]  sig;
    logic [7:0]  cadd;

    initial
    begin
        cyc = 1'b0;
        stb = 1'b0;
        we  = 1'b0;
        adr = 6'h00;
        sel = 4'h0;
        dat = 32'h0;
    end

    // one classic cycle; a random gap of idle cycles makes it slow or prompt
    task automatic wb(input logic w, input logic [5:0] a,
                      input logic [31:0] d, output logic ok);
        int n;
        n = 0;
        repeat ($urandom_range(2)) @(posedge clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we  <= w;
        adr <= a;
        sel <= 4'hf;
        dat <= d;
        do
        begin
            @(posedge clk);
            n++;
        end
        while (ack !== 1'b1 && n < 50);
        ok = (ack === 1'b1);
        cyc <= 1'b0;
        stb <= 1'b0;
        // released lines show no stale value
        adr <= ~a;
        dat <= ~d;
        @(posedge clk);
    endtask

    task automatic init_ov();
        ov[0] = 16'h0001;
        ov[1] = 16'h0007;
        ov[2] = 16'h003f;
        ov[3] = 16'h0000;
        ov[4] = 16'h0000;
        ov[5] = 16'h0000;
        ov[6] = 16'h0400;
        ov[7] = 16'h01ff;
        for (int i = 8; i < 255; i++)
            ov[i] = 16'($urandom);
        sig = 8'ha5;
        cadd = 8'h00;
    endtask

    task automatic send(output logic ok);
        logic [7:0] s;
        logic       o;
        s = sig;
        for (int i = 0; i < 255; i++)
            s = s + ov[i][7:0] + ov[i][15:8];
        ov[255] = {8'h00 - s + cadd, sig};
        wb(1'b1, 6'h00, 32'h1, ok);
        for (int i = 0; i < 256; i++)
        begin
            wb(1'b1, 6'h04, {16'h0, ov[i]}, o);
            ok = ok & o;
        end
    endtask
endmodule // coc_host
`default_nettype wire

// >>> tb/testbench.sv
// self-checking bench of the overlay checker
`timescale 1ns/1ps
`default_nettype none
`include "coc_regs.svh"
module testbench;
    logic        clk = 1'b0;
    logic        srst = 1'b1;
    logic        cyc, stb, we, ack, done, ok, ab;
    logic [5:0]  adr;
    logic [3:0]  sel;
    logic [31:0] wdat, rdat;
    logic [2:0]  mw_sel = 3'h0;
    logic [2:0]  u_sel = 3'h0;
    logic        mw_v = 1'b0;
    logic        u_v = 1'b0;
    logic        hpa = 1'b0;
    logic        puis = 1'b0;
    logic        sec = 1'b0;
    logic        smart = 1'b0;
    logic [63:0] rq [$];
    int          dq [$];
    logic [63:0] e;
    logic [15:0] xc [7];
    logic [7:0]  xch;
    logic [7:0]  xsn;
    logic [3:0]  ri [7];
    int          cnt = 0;
    int          n_errors = 0;
    int          samples_checked = 0;

    always #10 clk = ~clk;

    coc_host coc_host_inst (.clk(clk), .cyc(cyc), .stb(stb), .we(we),
        .adr(adr), .sel(sel), .dat(wdat), .ack(ack));

    coc_top coc_top_inst (.CLK(clk), .SRST(srst), .WB_CYC_I(cyc),
        .WB_STB_I(stb), .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(sel),
        .WB_DAT_I(wdat), .WB_DAT_O(rdat), .WB_ACK_O(ack),
        .MWDMA_SEL(mw_sel), .MWDMA_SEL_VALID(mw_v), .UDMA_SEL(u_sel),
        .UDMA_SEL_VALID(u_v), .HPA_SET(hpa), .PUIS_JUMPER(puis),
        .SECURITY_ON(sec), .SMART_ON(smart), .CMD_DONE(done));

    task automatic check(string nm, logic [31:0] x, logic [31:0] g);
        samples_checked++;
        if (g !== x)
        begin
            $display("[FAIL] %s expected %h seen %h", nm, x, g);
            n_errors++;
        end
    endtask

    task automatic conclude();
        $display("checks %0d errors %0d", samples_checked, n_errors);
        if (n_errors == 0 && samples_checked > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    task automatic timeout(logic o);
        if (!o)
        begin
            $display("[FAIL] ack wait expected 1 seen 0");
            n_errors++;
            conclude();
        end
    endtask

    task automatic rd(logic [3:0] i, logic [31:0] x, logic [31:0] m);
        logic o;
        rq.push_back({m, x & m});
        coc_host_inst.wb(1'b0, {i, 2'b00}, 32'h0, o);
        timeout(o);
    endtask

    // results are matched in order of appearance
    always @(posedge clk)
    begin
        if (ack === 1'b1 && we === 1'b0 && rq.size() > 0)
        begin
            e = rq.pop_front();
            check("read data", e[31:0], rdat & e[63:32]);
        end
        if (done === 1'b1)
        begin
            if (dq.size() == 0)
                check("done pulse", 32'h0, 32'h1);
            else
                check("done delay", 32'(dq.pop_front()), 32'(cnt + 1));
        end
        cnt <= (ack === 1'b1 && we === 1'b1) ? 0 : cnt + 1;
    end

    initial
    begin
        void'($urandom(32'h7266));
        ri = '{`COC_ADR_W63, `COC_ADR_W88, `COC_ADR_W82, `COC_ADR_W83,
               `COC_ADR_W84, `COC_ADR_W94, `COC_ADR_MAXLBA1};
        repeat (20) @(posedge clk);
        for (int c = 0; c < 17; c++)
        begin
            xc = '{16'h0007, 16'h003f, 16'h0403, 16'h0762, 16'h0003,
                   16'h8080, 16'h0400};
            ab = 1'b1;
            xch = 8'h07;
            xsn = 8'h00;
            mw_sel <= 3'h0;
            mw_v <= 1'b0;
            u_sel <= 3'($urandom_range(4));
            u_v <= 1'b0;
            hpa <= 1'b0;
            puis <= 1'b0;
            sec <= 1'b0;
            smart <= 1'b0;
            srst <= 1'b1;
            // defaults and scenario pins land on separate edges
            @(posedge clk);
            coc_host_inst.init_ov();
            case (c)
                0:
                begin
                    coc_host_inst.ov[1] = 16'h0003;
                    coc_host_inst.ov[2] = 16'h001f;
                    coc_host_inst.ov[7] = 16'h019f;
                    coc_host_inst.ov[6] = 16'h0200;
                    ab = 1'b0;
                    xc[0] = 16'h0003;
                    xc[1] = 16'h001f;
                    xc[3] = 16'h0560;
                    xc[5] = 16'h0000;
                    xc[6] = 16'h0200;
                end
                1:
                begin
                    coc_host_inst.ov[1] = 16'h0003;
                    mw_sel <= 3'h2;
                    mw_v <= 1'b1;
                    xch = 8'h01;
                    xsn = 8'h04;
                end
                2:
                begin
                    coc_host_inst.ov[1] = 16'h0006;
                    xch = 8'h01;
                    xsn = 8'h01;
                end
                3:
                begin
                    coc_host_inst.ov[0] = 16'h0002;
                    xch = 8'h00;
                end
                4:
                begin
                    coc_host_inst.cadd = 8'h01;
                    xch = 8'hff;
                end
                5:
                begin
                    coc_host_inst.sig = 8'ha4;
                    xch = 8'hff;
                end
                6:
                begin
                    hpa <= 1'b1;
                    coc_host_inst.ov[6] = 16'h0200;
                    xch = 8'h03;
                end
                7:
                begin
                    hpa <= 1'b1;
                    coc_host_inst.ov[7] = 16'h017f;
                    xsn = 8'h80;
                end
                8:
                begin
                    puis <= 1'b1;
                    coc_host_inst.ov[7] = 16'h01ef;
                    xsn = 8'h10;
                end
                9:
                begin
                    sec <= 1'b1;
                    coc_host_inst.ov[7] = 16'h01f7;
                    xsn = 8'h08;
                end
                10:
                begin
                    coc_host_inst.ov[7] = 16'h01fe;
                    xsn = 8'h01;
                end
                11:
                begin
                    coc_host_inst.ov[2] = 16'h0037;
                    xsn = 8'h08;
                    xch = 8'h02;
                end
                12:
                begin
                    coc_host_inst.ov[1] = 16'h0005;
                    xsn = 8'h02;
                    xch = 8'h01;
                end
                13:
                begin
                    coc_host_inst.ov[7] = 16'h00ff;
                    ab = 1'b0;
                    xc[3] = 16'h0362;
                    xc[6] = 16'h0000;
                end
                14:
                begin
                    coc_host_inst.ov[7] = 16'h0100;
                    ab = 1'b0;
                    xc[2] = 16'h0000;
                    xc[3] = 16'h0400;
                    xc[4] = 16'h0000;
                    xc[5] = 16'h0000;
                end
                16:
                begin
                    smart <= 1'b1;
                    coc_host_inst.ov[7] = 16'h01f8;
                    xsn = 8'h01;
                end
                default:
                begin
                    coc_host_inst.ov[2] = 16'h001f;
                    u_sel <= 3'h5;
                    u_v <= 1'b1;
                    xch = 8'h02;
                    xsn = 8'h20;
                end
            endcase
            repeat (3) @(posedge clk);
            srst <= 1'b0;
            @(posedge clk);
            dq.push_back(ab ? 1 : 2);
            coc_host_inst.send(ok);
            timeout(ok);
            rd(`COC_ADR_STAT, ab ? 32'h41 : 32'h40, 32'hffffffff);
            if (ab)
                rd(`COC_ADR_RESULT, {8'h04, xsn, 8'h00, xch},
                   32'hffffffff);
            for (int k = 0; k < 7; k++)
                rd(ri[k], {16'h0, xc[k]}, 32'h0000ffff);
            rd(`COC_ADR_MAXLBA0, 32'h0, 32'hffffffff);
        end
        coc_host_inst.wb(1'b1, 6'h3c, 32'h5a5a, ok);
        timeout(ok);
        rd(4'hf, 32'h0, 32'hffffffff);
        repeat (5) @(posedge clk);
        check("pending", 32'h0, 32'(dq.size() + rq.size()));
        conclude();
    end
endmodule // testbench
`default_nettype wire
